// [shared/flash_irq_pkg.sv]
// constants, types and register map of the flash interrupt status block
package flash_irq_pkg;
	// register byte offsets, decoded on the low address bits
	localparam int unsigned DEC_W = 12;
	localparam logic [11:0] RAW_STATUS_OFS = 12'h00c;
	localparam logic [11:0] MASK_OFS = 12'h010;
	localparam logic [11:0] MASKED_CLEAR_OFS = 12'h014;
	// field positions, shared by all three registers
	localparam int unsigned ACCESS_BIT = 0;
	localparam int unsigned PROG_BIT = 1;
	localparam int unsigned SRC_W = 2;
	// values after reset
	localparam logic [1:0] RAW_RESET = 2'h0;
	localparam logic [1:0] MASK_RESET = 2'h0;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	localparam logic HREADY_RESET = 1'h1;
	// ahb-lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;
	// one-hot bus slave states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} bus_state_e;
	// one bit for each interrupt source
	typedef struct packed {
		logic prog_done;
		logic access_fault;
	} irq_src_s;
	// address phase captured for the data phase
	typedef struct packed {
		logic [11:0] addr;
		logic write;
	} bus_req_s;
endpackage : flash_irq_pkg

// [hdl/sticky_flag.sv]
// one sticky status bit: hardware sets it, software clears it
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// set and clear requests
	input wire logic set,
	input wire logic clr,
	// stored state
	output logic flag_q
);
	logic flag_d;

	// a set in the same cycle as a clear wins so no event is lost
	always_comb begin
		flag_d = flag_q;
		if (clr) begin
			flag_d = 1'b0;
		end
		if (set) begin
			flag_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end
endmodule : sticky_flag
`default_nettype wire

// [hdl/flash_ctrl_interrupt_status.sv]
// flash controller interrupt status, mask and clear registers behind ahb-lite
// What this block does
// - interrupt only when raw set and mask set
// - program/erase completion sets raw bit 1
// - protection violation sets raw bit 0
// - mask bit 1 passes programming completion
// - mask bit 0 passes access violation
// - masked sources still recorded; masks reset zero
// - masked status bit 1 shows programming completion
// - masked status bit 0 shows access violation
// - writing one clears bit; zero leaves it
// - clearing masked programming bit clears raw bit
// - clearing masked access bit clears raw bit
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_interrupt_status (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// events from sequencer and protection checker, one-cycle pulses
	input wire logic prog_done_event,
	input wire logic access_fault_event,
	// interrupt to the processor interrupt controller
	output logic flash_irq
);
	flash_irq_pkg::bus_state_e state_q;
	flash_irq_pkg::bus_state_e state_d;
	flash_irq_pkg::bus_req_s req_q;
	flash_irq_pkg::bus_req_s req_d;
	flash_irq_pkg::irq_src_s raw_q;
	flash_irq_pkg::irq_src_s mask_q;
	flash_irq_pkg::irq_src_s mask_d;
	flash_irq_pkg::irq_src_s masked;
	flash_irq_pkg::irq_src_s clear;
	logic [31:0] hrdata_q;
	logic [31:0] hrdata_d;
	logic hreadyout_q;
	logic hreadyout_d;
	logic irq_q;
	logic irq_d;
	logic take;
	logic wr_mask;
	logic wr_clear;
	logic rd_en;

	// hsize is not checked: only whole-word single transfers are expected
	assign take = hsel && hready && (htrans == flash_irq_pkg::HTRANS_NONSEQ);
	assign wr_mask = (state_q == flash_irq_pkg::ST_BUSY) && req_q.write &&
		(req_q.addr == flash_irq_pkg::MASK_OFS);
	assign wr_clear = (state_q == flash_irq_pkg::ST_BUSY) && req_q.write &&
		(req_q.addr == flash_irq_pkg::MASKED_CLEAR_OFS);
	assign rd_en = (state_q == flash_irq_pkg::ST_BUSY) && !req_q.write;

	// bus slave: one wait cycle so that read data leaves a flip-flop
	always_comb begin
		state_d = state_q;
		req_d = req_q;
		hreadyout_d = hreadyout_q;
		unique case (state_q)
			flash_irq_pkg::ST_IDLE: begin
				hreadyout_d = 1'b1;
				if (take) begin
					req_d.addr = haddr[flash_irq_pkg::DEC_W-1:0];
					req_d.write = hwrite;
					hreadyout_d = 1'b0;
					state_d = flash_irq_pkg::ST_BUSY;
				end
			end
			flash_irq_pkg::ST_BUSY: begin
				hreadyout_d = 1'b1;
				state_d = flash_irq_pkg::ST_IDLE;
			end
			default: begin
				hreadyout_d = 1'b1;
				state_d = flash_irq_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= flash_irq_pkg::ST_IDLE;
			req_q <= '0;
			hreadyout_q <= flash_irq_pkg::HREADY_RESET;
		end else begin
			state_q <= state_d;
			req_q <= req_d;
			hreadyout_q <= hreadyout_d;
		end
	end

	// masked view, also the source of the interrupt
	assign masked.prog_done = raw_q.prog_done && mask_q.prog_done;
	assign masked.access_fault = raw_q.access_fault && mask_q.access_fault;

	// a one clears the masked bit by clearing the raw bit under it; zeros do nothing
	assign clear.prog_done = wr_clear && hwdata[flash_irq_pkg::PROG_BIT];
	assign clear.access_fault = wr_clear && hwdata[flash_irq_pkg::ACCESS_BIT];

	// raw bits record regardless of the mask
	sticky_flag u_prog_raw (
		.clk(hclk),
		.rst_n(hresetn),
		.set(prog_done_event),
		.clr(clear.prog_done),
		.flag_q(raw_q.prog_done)
	);

	sticky_flag u_access_raw (
		.clk(hclk),
		.rst_n(hresetn),
		.set(access_fault_event),
		.clr(clear.access_fault),
		.flag_q(raw_q.access_fault)
	);

	// mask register; upper bits of the written word are dropped
	always_comb begin
		mask_d = mask_q;
		if (wr_mask) begin
			mask_d.prog_done = hwdata[flash_irq_pkg::PROG_BIT];
			mask_d.access_fault = hwdata[flash_irq_pkg::ACCESS_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_q <= flash_irq_pkg::MASK_RESET;
		end else begin
			mask_q <= mask_d;
		end
	end

	// read mux; reserved bits and unmapped offsets read zero
	always_comb begin
		hrdata_d = hrdata_q;
		if (rd_en) begin
			hrdata_d = '0;
			unique case (req_q.addr)
				flash_irq_pkg::RAW_STATUS_OFS: begin
					hrdata_d[flash_irq_pkg::SRC_W-1:0] = raw_q;
				end
				flash_irq_pkg::MASK_OFS: begin
					hrdata_d[flash_irq_pkg::SRC_W-1:0] = mask_q;
				end
				flash_irq_pkg::MASKED_CLEAR_OFS: begin
					hrdata_d[flash_irq_pkg::SRC_W-1:0] = masked;
				end
				default: begin
					hrdata_d = '0;
				end
			endcase
		end
	end

	// the interrupt is registered, so it trails the status by one cycle
	always_comb begin
		irq_d = masked.prog_done || masked.access_fault;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= flash_irq_pkg::RDATA_RESET;
			irq_q <= 1'b0;
		end else begin
			hrdata_q <= hrdata_d;
			irq_q <= irq_d;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = flash_irq_pkg::HRESP_OKAY;
	assign flash_irq = irq_q;

	// checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	irq_follows_a: assert property (
		(!mask_q.prog_done && !mask_q.access_fault) |=> !flash_irq
	) else $error("interrupt raised with both sources masked");

	irq_or_a: assert property (
		##1 (flash_irq == $past(masked.prog_done || masked.access_fault))
	) else $error("interrupt is not the or of the masked bits");

	prog_set_a: assert property (
		prog_done_event |=> raw_q.prog_done
	) else $error("programming completion not recorded");

	prog_quiet_a: assert property (
		(!prog_done_event && !raw_q.prog_done) |=> !raw_q.prog_done
	) else $error("programming raw bit set without completion");

	access_set_a: assert property (
		access_fault_event |=> raw_q.access_fault
	) else $error("protection violation not recorded");

	masked_rec_a: assert property (
		(access_fault_event && !mask_q.access_fault && !wr_mask) |=>
			(raw_q.access_fault && !masked.access_fault)
	) else $error("masked access source not recorded or not withheld");

	mask_write_a: assert property (
		wr_mask |=> (mask_q == $past(hwdata[1:0]))
	) else $error("mask register did not take the written value");

	prog_clear_a: assert property (
		(clear.prog_done && !prog_done_event) |=> !raw_q.prog_done
	) else $error("programming bit not cleared by write of one");

	access_clear_a: assert property (
		(clear.access_fault && !access_fault_event) |=> !raw_q.access_fault
	) else $error("access bit not cleared by write of one");

	zero_keeps_a: assert property (
		(wr_clear && !hwdata[flash_irq_pkg::PROG_BIT] && raw_q.prog_done) |=>
			raw_q.prog_done
	) else $error("write of zero cleared the programming bit");

	masked_read_a: assert property (
		(rd_en && req_q.addr == flash_irq_pkg::MASKED_CLEAR_OFS) |=>
			(hrdata[1:0] == $past(masked) && hrdata[31:2] == 30'h0)
	) else $error("masked status read back wrong");

	wait_state_a: assert property (
		(take && state_q == flash_irq_pkg::ST_IDLE) |=> !hreadyout ##1 hreadyout
	) else $error("bus answer not after exactly one wait cycle");

	access_quiet_a: assert property (
		(!access_fault_event && !raw_q.access_fault) |=> !raw_q.access_fault
	) else $error("access raw bit set without a violation");

	prog_masked_rec_a: assert property (
		(prog_done_event && !mask_q.prog_done && !wr_mask) |=>
			(raw_q.prog_done && !masked.prog_done)
	) else $error("masked programming source not recorded or not withheld");

	prog_pass_a: assert property (
		masked.prog_done |=> flash_irq
	) else $error("enabled programming completion not passed on");

	access_pass_a: assert property (
		masked.access_fault |=> flash_irq
	) else $error("enabled protection violation not passed on");

	access_keeps_a: assert property (
		(wr_clear && !hwdata[flash_irq_pkg::ACCESS_BIT] && raw_q.access_fault) |=>
			raw_q.access_fault
	) else $error("write of zero cleared the access bit");

	irq_rise_c: cover property ($rose(flash_irq));
	prog_clear_c: cover property (raw_q.prog_done ##1 clear.prog_done ##1 !flash_irq);
	masked_fault_c: cover property (access_fault_event && !mask_q.access_fault);
	set_wins_c: cover property (prog_done_event && clear.prog_done);
	access_clear_c: cover property (raw_q.access_fault ##1 clear.access_fault);
endmodule : flash_ctrl_interrupt_status
`default_nettype wire

// [verification/irq_sink.sv]
// processor-side interrupt sink that counts requests from the flash block
`timescale 1ns/1ps
`default_nettype none
module irq_sink (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// interrupt level from the block
	input wire logic flash_irq,
	// rising edges seen so far
	output logic [15:0] rises_q
);
	logic seen_q;
	// a level input: only new requests are counted, a held level is one request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seen_q <= 1'b0;
			rises_q <= 16'h0000;
		end else begin
			seen_q <= flash_irq;
			if (flash_irq && !seen_q) begin
				rises_q <= rises_q + 16'h0001;
			end
		end
	end
endmodule : irq_sink
`default_nettype wire

// [verification/flash_ctrl_interrupt_status_bench.sv]
// self-checking bench for the flash interrupt status block
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_interrupt_status_bench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic prog_done_event = 1'b0;
	logic access_fault_event = 1'b0;
	logic hreadyout, hresp, flash_irq;
	logic [31:0] hrdata, rd, d;
	logic [15:0] rises;
	logic [1:0] exp_raw = 2'h0;
	logic [1:0] exp_mask = 2'h0;
	int fails = 0;
	int checks_done = 0;
	int seed_v;
	always #25 hclk = ~hclk;
	flash_ctrl_interrupt_status dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.prog_done_event(prog_done_event), .access_fault_event(access_fault_event),
		.flash_irq(flash_irq));
	irq_sink sink_u (.hclk(hclk), .hresetn(hresetn), .flash_irq(flash_irq), .rises_q(rises));
	function automatic logic [1:0] masked_of(input logic [1:0] raw, input logic [1:0] mask);
		return raw & mask;
	endfunction : masked_of
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= flash_irq_pkg::HTRANS_NONSEQ;
		haddr <= {20'h00000, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus
	task automatic pulse(input logic [1:0] ev);
		@(posedge hclk);
		prog_done_event <= ev[1];
		access_fault_event <= ev[0];
		@(posedge hclk);
		prog_done_event <= 1'b0;
		access_fault_event <= 1'b0;
		exp_raw = exp_raw | ev;
	endtask : pulse
	task automatic check_all;
		logic [31:0] r;
		logic [1:0] m;
		m = masked_of(exp_raw, exp_mask);
		bus(1'b0, flash_irq_pkg::RAW_STATUS_OFS, 32'h0, r);
		check(r, {30'h0, exp_raw});
		bus(1'b0, flash_irq_pkg::MASK_OFS, 32'h0, r);
		check(r, {30'h0, exp_mask});
		bus(1'b0, flash_irq_pkg::MASKED_CLEAR_OFS, 32'h0, r);
		check(r, {30'h0, m});
		check({31'h0, flash_irq}, {31'h0, |m});
		check({31'h0, hresp}, 32'h0);
	endtask : check_all
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done
	initial begin
		seed_v = $urandom(84603);
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		check_all;
		$display("test reset done");
		// masked-off events must still be recorded, and stray writes must not touch them
		pulse(2'h3);
		bus(1'b1, flash_irq_pkg::RAW_STATUS_OFS, 32'h0000_0000, rd);
		bus(1'b1, flash_irq_pkg::MASKED_CLEAR_OFS, 32'h0000_0000, rd);
		check_all;
		bus(1'b1, flash_irq_pkg::MASK_OFS, 32'h0000_0003, rd);
		exp_mask = 2'h3;
		check_all;
		bus(1'b1, flash_irq_pkg::MASKED_CLEAR_OFS, 32'h0000_0002, rd);
		exp_raw = exp_raw & 2'h1;
		check_all;
		bus(1'b1, flash_irq_pkg::MASKED_CLEAR_OFS, 32'h0000_0001, rd);
		exp_raw = 2'h0;
		check_all;
		bus(1'b1, 12'h018, 32'hffff_ffff, rd);
		bus(1'b0, 12'h018, 32'h0, rd);
		check(rd, 32'h0);
		// an event landing in the very cycle of its clear must survive it
		fork
			bus(1'b1, flash_irq_pkg::MASKED_CLEAR_OFS, 32'h0000_0002, rd);
			begin
				@(posedge hclk);
				pulse(2'h2);
			end
		join
		check_all;
		$display("test corners done");
		for (int i = 0; i < 40; i++) begin
			pulse(2'($urandom_range(0, 3)));
			d = {30'h0, 2'($urandom)};
			case ($urandom_range(0, 2))
				0: begin
					bus(1'b1, flash_irq_pkg::MASK_OFS, d, rd);
					exp_mask = d[1:0];
				end
				1: begin
					bus(1'b1, flash_irq_pkg::MASKED_CLEAR_OFS, d, rd);
					exp_raw = exp_raw & ~d[1:0];
				end
				default: bus(1'b1, flash_irq_pkg::RAW_STATUS_OFS, d, rd);
			endcase
			check_all;
		end
		check({31'h0, rises != 16'h0000}, 32'h1);
		$display("test random done");
		// a reset in mid-run must bring every register and the interrupt back to rest
		pulse(2'h3);
		bus(1'b1, flash_irq_pkg::MASK_OFS, 32'h0000_0003, rd);
		@(posedge hclk);
		check({31'h0, flash_irq}, 32'h1);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		exp_raw = 2'h0;
		exp_mask = 2'h0;
		check_all;
		$display("test second reset done");
		test_done;
	end
	// the run needs under 1000 cycles; forty times that means a hang
	initial begin
		#(50 * 40000);
		fails++;
		test_done;
	end
endmodule : flash_ctrl_interrupt_status_bench
`default_nettype wire
